// *** hdl/vibf_pkg.sv ***
// Constants and types shared by the video input blanking and field flag block.
// Assumes one parallel video clock domain and a classic Wishbone register slave.
package vibf_pkg;

    localparam int           VIBF_DATA_W         = 10;
    localparam int           VIBF_WB_ADDR_W      = 8;

    // Register byte addresses.
    localparam logic [7:0]   VIBF_CTRL_ADDR      = 8'h00;
    localparam logic [7:0]   VIBF_STAT_ADDR      = 8'h04;

    // Control register fields and reset value.
    localparam int           VIBF_CTRL_AUTODET   = 0;
    localparam int           VIBF_CTRL_IOPROC    = 1;
    localparam logic [1:0]   VIBF_CTRL_RESET     = 2'h2;

    // Status register fields.
    localparam int           VIBF_STAT_FIELD     = 0;
    localparam int           VIBF_STAT_BLANK     = 1;
    localparam int           VIBF_STAT_TRSF      = 2;

    // Blanking levels for 10-bit video words.
    localparam logic [9:0]   VIBF_LUMA_BLANK     = 10'h040;
    localparam logic [9:0]   VIBF_CHROMA_BLANK   = 10'h200;

    // TRS preamble words and position of the field bit in the XYZ word.
    localparam logic [9:0]   VIBF_TRS_W0         = 10'h3ff;
    localparam logic [9:0]   VIBF_TRS_W1         = 10'h000;
    localparam int           VIBF_XYZ_FBIT       = 8;

    typedef enum logic [1:0] {
        VIBF_S_IDLE = 2'b00,
        VIBF_S_P1   = 2'b01,
        VIBF_S_P2   = 2'b11,
        VIBF_S_XYZ  = 2'b10
    } vibf_trs_e;

    function automatic logic vibf_is_word(input logic [9:0] w, input logic [9:0] ref_w);
        vibf_is_word = (w == ref_w);
    endfunction

endpackage

// *** hdl/vibf_wb_regs.sv ***
// Classic Wishbone slave holding the control and status registers.
// Assumes a single-cycle master that holds the request until ack is seen.
`timescale 1ns/10ps
`default_nettype none
module vibf_wb_regs
    import vibf_pkg::*;
(
    input  wire logic                      clk_sys_i,
    input  wire logic                      nrst_i,
    input  wire logic                      ce_i,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [VIBF_WB_ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    input  wire logic [2:0]                status_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    output logic      [1:0]                ctrl_o
);

    logic [1:0]  ctrl_r, ctrl_nxt;
    logic        ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic        req;

    // Ack is given one cycle after the request and dropped the next cycle. A write
    // lands at the edge where ack stands, which is the edge the master acts on.
    always_comb
    begin
        req      = wb_cyc_i && wb_stb_i && !ack_r;
        ctrl_nxt = ctrl_r;
        ack_nxt  = req;
        dat_nxt  = 32'h0;
        if (wb_cyc_i && wb_stb_i && ack_r && wb_we_i && wb_sel_i[0] && wb_adr_i == VIBF_CTRL_ADDR)
        begin
            ctrl_nxt = wb_dat_i[1:0];
        end
        if (req && !wb_we_i)
        begin
            unique case (wb_adr_i)
                VIBF_CTRL_ADDR: dat_nxt = {30'h0, ctrl_r};
                VIBF_STAT_ADDR: dat_nxt = {29'h0, status_i};
                default:        dat_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ctrl_r <= VIBF_CTRL_RESET;
            ack_r  <= 1'b0;
            dat_r  <= 32'h0;
        end
        else if (ce_i)
        begin
            ctrl_r <= ctrl_nxt;
            ack_r  <= ack_nxt;
            dat_r  <= dat_nxt;
        end
    end

    assign ctrl_o   = ctrl_r;
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

endmodule // vibf_wb_regs
`default_nettype wire

// *** hdl/vibf_skid.sv ***
// Two-entry buffer with valid and ready on both sides.
// Assumes the drain side may stall at any time; no word is lost.
`timescale 1ns/10ps
`default_nettype none
module vibf_skid #(
    parameter int W = 20
) (
    input  wire logic         clk_sys_i,
    input  wire logic         nrst_i,
    input  wire logic         ce_i,
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    output logic              out_valid_o,
    output logic      [W-1:0] out_data_o,
    input  wire logic         out_ready_i
);

    logic [W-1:0] mem_r [2];
    logic [W-1:0] mem_nxt [2];
    logic [1:0]   cnt_r, cnt_nxt;
    logic         push, pop;

    always_comb
    begin
        push       = in_valid_i && (cnt_r != 2'd2);
        pop        = out_ready_i && (cnt_r != 2'd0);
        mem_nxt[0] = mem_r[0];
        mem_nxt[1] = mem_r[1];
        cnt_nxt    = cnt_r;
        if (pop)
        begin
            mem_nxt[0] = mem_r[1];
        end
        if (push)
        begin
            if (cnt_r == 2'd0 || (cnt_r == 2'd1 && pop))
                mem_nxt[0] = in_data_i;
            else
                mem_nxt[1] = in_data_i;
        end
        cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            mem_r[0] <= '0;
            mem_r[1] <= '0;
            cnt_r    <= 2'd0;
        end
        else if (ce_i)
        begin
            mem_r[0] <= mem_nxt[0];
            mem_r[1] <= mem_nxt[1];
            cnt_r    <= cnt_nxt;
        end
    end

    assign in_ready_o  = (cnt_r != 2'd2);
    assign out_valid_o = (cnt_r != 2'd0);
    assign out_data_o  = mem_r[0];

endmodule // vibf_skid
`default_nettype wire

// *** hdl/vibf_top.sv ***
// Video input blanking and TRS field flag stage of a parallel video input.
// Assumes blank and field inputs are synchronous to clk_sys_i and a Wishbone master.
`timescale 1ns/10ps
`default_nettype none
module vibf_top
    import vibf_pkg::*;
#(
    parameter int DW = VIBF_DATA_W
) (
    input  wire logic                      clk_sys_i,
    input  wire logic                      nrst_i,
    input  wire logic                      ce_i,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [VIBF_WB_ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    input  wire logic                      vid_valid_i,
    input  wire logic [DW-1:0]             luma_i,
    input  wire logic [DW-1:0]             chroma_i,
    input  wire logic                      blank_n_i,
    input  wire logic                      field_i,
    output logic                           vid_ready_o,
    output logic                           vid_valid_o,
    output logic      [DW-1:0]             luma_o,
    output logic      [DW-1:0]             chroma_o,
    input  wire logic                      vid_ready_i
);

    logic [1:0]    ctrl;
    logic          autodet, ioproc;
    logic          take;
    logic [DW-1:0] luma_s, chroma_s;
    logic          in_ready;
    logic          out_valid;
    logic [2*DW-1:0] out_data;
    logic          blank_r, blank_nxt;
    logic          field_r, field_nxt;
    logic          trsf_r, trsf_nxt;
    vibf_trs_e     st_r, st_nxt;
    logic          vr_r, vv_r;
    logic [DW-1:0] lo_r, co_r;
    logic          vr_nxt, vv_nxt;
    logic [DW-1:0] lo_nxt, co_nxt;
    logic          out_ready, buf_pop;

    assign autodet = ctrl[VIBF_CTRL_AUTODET];
    assign ioproc  = ctrl[VIBF_CTRL_IOPROC];
    assign take    = vid_valid_i && vr_r;

    vibf_wb_regs u_regs (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .ce_i      (ce_i),
        .wb_cyc_i  (wb_cyc_i),
        .wb_stb_i  (wb_stb_i),
        .wb_we_i   (wb_we_i),
        .wb_adr_i  (wb_adr_i),
        .wb_sel_i  (wb_sel_i),
        .wb_dat_i  (wb_dat_i),
        .status_i  ({trsf_r, blank_r, field_r}),
        .wb_dat_o  (wb_dat_o),
        .wb_ack_o  (wb_ack_o),
        .ctrl_o    (ctrl)
    );

    // TRS tracking on the luma stream and word substitution on both streams. The field bit is
    // written only in XYZ words, so the preamble words are never disturbed.
    always_comb
    begin
        st_nxt    = st_r;
        blank_nxt = blank_r;
        field_nxt = field_r;
        trsf_nxt  = trsf_r;
        luma_s    = luma_i;
        chroma_s  = chroma_i;
        if (take)
        begin
            blank_nxt = !blank_n_i;
            field_nxt = field_i;
            unique case (st_r)
                VIBF_S_IDLE: st_nxt = vibf_is_word(luma_i, VIBF_TRS_W0) ? VIBF_S_P1 : VIBF_S_IDLE;
                VIBF_S_P1:   st_nxt = vibf_is_word(luma_i, VIBF_TRS_W1) ? VIBF_S_P2 : VIBF_S_IDLE;
                // Third preamble word seen: the next word is the XYZ word.
                VIBF_S_P2:   st_nxt = vibf_is_word(luma_i, VIBF_TRS_W1) ? VIBF_S_XYZ : VIBF_S_IDLE;
                VIBF_S_XYZ:
                begin
                    st_nxt = VIBF_S_IDLE;
                    if (!autodet && ioproc)
                    begin
                        luma_s[VIBF_XYZ_FBIT] = field_i;
                        trsf_nxt = field_i;
                    end
                end
            endcase
            // Blanking covers the whole line, ancillary spaces included; TRS words
            // are also blanked, which a later TRS inserter must regenerate.
            if (!blank_n_i)
            begin
                luma_s   = VIBF_LUMA_BLANK;
                chroma_s = VIBF_CHROMA_BLANK;
            end
            // Otherwise the words go on untouched, except the XYZ field bit when ioproc is set and autodet clear.
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st_r    <= VIBF_S_IDLE;
            blank_r <= 1'b0;
            field_r <= 1'b0;
            trsf_r  <= 1'b0;
        end
        else if (ce_i)
        begin
            st_r    <= st_nxt;
            blank_r <= blank_nxt;
            field_r <= field_nxt;
            trsf_r  <= trsf_nxt;
        end
    end

    vibf_skid #(
        .W (2*DW)
    ) u_buf (
        .clk_sys_i   (clk_sys_i),
        .nrst_i      (nrst_i),
        .ce_i        (ce_i),
        .in_valid_i  (take),
        .in_data_i   ({luma_s, chroma_s}),
        .in_ready_o  (in_ready),
        .out_valid_o (out_valid),
        .out_data_o  (out_data),
        .out_ready_i (out_ready)
    );

    // Output flops form one more stage: a word stands until the sink takes it,
    // and the buffer hands over its head only when that stage is empty or drains.
    // Ready is worked out a cycle ahead from the buffer's fill, so it is exact
    // although it comes from a flop; a stale ready would let a word be lost.
    always_comb
    begin
        out_ready = !vv_r || vid_ready_i;
        buf_pop   = out_ready && out_valid;
        vv_nxt    = vv_r;
        lo_nxt    = lo_r;
        co_nxt    = co_r;
        vr_nxt    = !((!in_ready && !buf_pop) || (in_ready && out_valid && take && !buf_pop));
        if (out_ready)
        begin
            vv_nxt = out_valid;
            lo_nxt = out_data[2*DW-1:DW];
            co_nxt = out_data[DW-1:0];
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            vr_r <= 1'b0;
            vv_r <= 1'b0;
            lo_r <= '0;
            co_r <= '0;
        end
        else if (ce_i)
        begin
            vr_r <= vr_nxt;
            vv_r <= vv_nxt;
            lo_r <= lo_nxt;
            co_r <= co_nxt;
        end
    end

    assign vid_ready_o = vr_r;
    assign vid_valid_o = vv_r;
    assign luma_o      = lo_r;
    assign chroma_o    = co_r;

    a_blank_forces: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (ce_i && take && !blank_n_i) |-> (luma_s == VIBF_LUMA_BLANK && chroma_s == VIBF_CHROMA_BLANK))
        else $error("blanking value not applied");
    a_pass_through: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (take && blank_n_i && st_r != VIBF_S_XYZ) |-> (luma_s == luma_i && chroma_s == chroma_i))
        else $error("video word altered");
    a_field_bit_set: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (take && blank_n_i && st_r == VIBF_S_XYZ && !autodet && ioproc)
        |-> (luma_s[VIBF_XYZ_FBIT] == field_i))
        else $error("field bit wrong in TRS word");
    a_autodet_ignore: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (take && blank_n_i && autodet) |-> (luma_s == luma_i))
        else $error("field input used in autodetect");
    a_sample_field: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (ce_i && take) |=> (field_r == $past(field_i) && blank_r == !$past(blank_n_i)))
        else $error("controls not sampled");

endmodule // vibf_top
`default_nettype wire

// *** testbench/vibf_src_model.sv ***
// Upstream video source: presents luma, chroma, blanking and field words.
// Assumes the caller runs its tasks just after a rising edge of clk_sys_i.
`timescale 1ns/10ps
`default_nettype none
module vibf_src_model
(
    input  wire logic       clk_sys_i,
    input  wire logic       ready_i,
    output logic            valid_o,
    output logic [9:0]      luma_o,
    output logic [9:0]      chroma_o,
    output logic            blank_n_o,
    output logic            field_o
);
    initial
    begin
        valid_o = 1'b0;
        luma_o = 10'h000;
        chroma_o = 10'h000;
        blank_n_o = 1'b1;
        field_o = 1'b0;
    end

    // The caller passes one field value for a whole line or frame.
    task automatic send(input logic [9:0] l, input logic [9:0] c, input logic b, input logic f);
        int n;
        n = 0;
        valid_o <= 1'b1;
        luma_o <= l;
        chroma_o <= c;
        blank_n_o <= b;
        field_o <= f;
        do
            @(posedge clk_sys_i);
        while (ready_i !== 1'b1 && ++n < 1000);
    endtask

    // Released data lines flip, so a stale word is never mistaken for a fresh one.
    task automatic idle();
        valid_o <= 1'b0;
        luma_o <= ~luma_o;
        chroma_o <= ~chroma_o;
    endtask
endmodule // vibf_src_model
`default_nettype wire

// *** testbench/vibf_top_test.sv ***
// Self-checking bench for the blanking and field flag stage.
// Assumes the source model is compiled before this file.
`timescale 1ns/10ps
`default_nettype none
module vibf_top_test;
    import vibf_pkg::*;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] rd;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, vid_ready_o, vid_valid_o, sv, sb, sf;
    logic vid_rdy = 1'b1;
    logic [9:0] sl, sc, luma_o, chroma_o, x0, x1;
    logic [19:0] got_q [$];
    int err_total = 0;
    int samples_checked = 0;

    vibf_top u_vibf_top (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .vid_valid_i(sv), .luma_i(sl), .chroma_i(sc),
        .blank_n_i(sb), .field_i(sf), .vid_ready_o(vid_ready_o), .vid_valid_o(vid_valid_o),
        .luma_o(luma_o), .chroma_o(chroma_o), .vid_ready_i(vid_rdy));
    vibf_src_model u_vibf_src_model (.clk_sys_i(clk_sys_i), .ready_i(vid_ready_o), .valid_o(sv),
        .luma_o(sl), .chroma_o(sc), .blank_n_o(sb), .field_o(sf));

    always #2 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i)
        if (vid_valid_o === 1'b1 && vid_rdy === 1'b1)
            got_q.push_back({luma_o, chroma_o});

    task automatic check10(input string nm, input logic [9:0] e, input logic [9:0] g);
        samples_checked++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic check32(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wb_io(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= 4'hf;
        wb_dat <= d;
        do
            @(posedge clk_sys_i);
        while (wb_ack_o !== 1'b1 && ++n < 50);
        rd = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_sys_i);
        if (n >= 50)
            check32("wb_ack", 32'h1, 32'h0);
    endtask

    // Sends one TRS preamble, its XYZ word and one active word, then judges them.
    task automatic run_line(input logic b, input logic f, input logic chk, output logic [9:0] xyz);
        logic [9:0] l [5];
        logic [19:0] w;
        int n;
        l = '{VIBF_TRS_W0, VIBF_TRS_W1, VIBF_TRS_W1, {1'b1, chk & ~f, 8'h00}, 10'h155};
        for (int i = 0; i < 5; i++)
            u_vibf_src_model.send(l[i], 10'h0a0 + 10'(i), b, f);
        u_vibf_src_model.idle();
        n = 0;
        while (got_q.size() < 5 && n++ < 200)
            @(posedge clk_sys_i);
        check10("word count", 10'h005, 10'(got_q.size()));
        for (int i = 0; i < 5 && got_q.size() > 0; i++)
        begin
            w = got_q.pop_front();
            if (i == 3)
                xyz = w[19:10];
            if (!b)
            begin
                check10("blank luma", VIBF_LUMA_BLANK, w[19:10]);
                check10("blank chroma", VIBF_CHROMA_BLANK, w[9:0]);
            end
            else
            begin
                if (i != 3)
                    check10("luma", l[i], w[19:10]);
                else if (chk)
                    check10("xyz", {1'b1, f, 8'h00}, w[19:10]);
                else
                    check10("xyz kept", l[i], w[19:10]);
                check10("chroma", 10'h0a0 + 10'(i), w[9:0]);
            end
        end
    endtask

    task automatic t_regs();
        wb_io(1'b0, VIBF_CTRL_ADDR, 32'h0);
        check32("ctrl reset", {30'h0, VIBF_CTRL_RESET}, rd);
        wb_io(1'b1, 8'h40, 32'hffffffff);
        wb_io(1'b0, 8'h40, 32'h0);
        check32("unmapped", 32'h0, rd);
        wb_io(1'b1, VIBF_CTRL_ADDR, 32'h3);
        wb_io(1'b0, VIBF_CTRL_ADDR, 32'h0);
        check32("ctrl rw", 32'h3, rd);
    endtask

    task automatic t_field();
        wb_io(1'b1, VIBF_CTRL_ADDR, 32'h2);
        run_line(1'b1, 1'b1, 1'b1, x0);
        run_line(1'b1, 1'b0, 1'b1, x0);
        wb_io(1'b1, VIBF_CTRL_ADDR, 32'h3);
        run_line(1'b1, 1'b0, 1'b0, x0);
        run_line(1'b1, 1'b1, 1'b0, x1);
        check10("field ignored", x0, x1);
        wb_io(1'b1, VIBF_CTRL_ADDR, 32'h0);
        run_line(1'b1, 1'b1, 1'b0, x1);
    endtask

    task automatic t_blank();
        wb_io(1'b1, VIBF_CTRL_ADDR, 32'h2);
        run_line(1'b0, 1'b1, 1'b1, x0);
        wb_io(1'b0, VIBF_STAT_ADDR, 32'h0);
        check32("stat", 32'h7, rd);
    endtask

    // The sink stalls until the buffer refuses, then drains with ready toggling.
    task automatic t_stall();
        logic [19:0] w;
        int n;
        n = 0;
        vid_rdy <= 1'b0;
        fork
            begin
                for (int i = 0; i < 6; i++)
                    u_vibf_src_model.send(10'h100 + 10'(i), 10'h300 + 10'(i), 1'b1, 1'b0);
                u_vibf_src_model.idle();
            end
            begin
                while (vid_ready_o !== 1'b0 && n++ < 50)
                    @(posedge clk_sys_i);
                check10("refuse", 10'h000, {9'h0, vid_ready_o});
                while (got_q.size() < 6 && n++ < 300)
                begin
                    @(posedge clk_sys_i);
                    vid_rdy <= ~vid_rdy;
                end
            end
        join
        @(posedge clk_sys_i);
        vid_rdy <= 1'b1;
        check10("stall count", 10'h006, 10'(got_q.size()));
        for (int i = 0; i < 6 && got_q.size() > 0; i++)
        begin
            w = got_q.pop_front();
            check10("stall luma", 10'h100 + 10'(i), w[19:10]);
            check10("stall chroma", 10'h300 + 10'(i), w[9:0]);
        end
    endtask

    task automatic test_done();
        $display("checked %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        @(posedge clk_sys_i);
        t_regs();
        t_field();
        t_blank();
        t_stall();
        test_done();
    end

    // The tests need about a hundred cycles; twenty thousand means a hang.
    initial
    begin
        #80000;
        err_total++;
        test_done();
    end
endmodule // vibf_top_test
`default_nettype wire
